// File: acm_ctl.sv
// acm_ctl: acquisition chain front-end control with wishbone register slave.
// assumes a classic wishbone master on clk_i; analog chain outputs are plain levels.
//
// Summary of operation
// - any write to a configuration register with byte lane 0 selected resets the gain stages, restarting settling
// - channel or reference change switches the selected inputs to the new choice
// - stage enable code 0001 bypasses all three gain stages, converter only
// - bias code 11 on both fields selects the largest bias current
// - lower bias setting lowers the maximum sampling rate of the chain
// - elementary conversion count is only stored in cfg3; no output carries it onward
// - multiplier register holds enable and clock division, cleared by reset
// - division codes 00..11 give system clock over 2, 4, 16, 64
`timescale 1ns/10ps
module acm_ctl (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 cyc_i,
   input  wire logic                 stb_i,
   input  wire logic                 we_i,
   input  wire logic [7:0]           adr_i,
   input  wire logic [3:0]           sel_i,
   input  wire logic [31:0]          dat_i,
   output logic      [31:0]          dat_o,
   output logic                      ack_o,
   output acm_pkg::acm_analog_t      analog_o,
   output logic                      conv_start_o,
   output logic                      settled_o,
   output logic                      vmult_en_o,
   output logic                      vmult_clk_o,
   output logic                      vmult_tick_o
);

   typedef struct packed {
      logic [4:0][7:0]        cfg;
      logic [7:0]             vmult;
      acm_pkg::acm_state_t    state;
      logic [14:0]            settle_cnt;
      logic                   early_start;
      logic                   start;
      logic                   pga_rst;
      logic                   ack;
      logic [31:0]            rdat;
   } acm_state_all_t;

   acm_state_all_t st_reg;
   acm_state_all_t st_next;

   logic        req;
   logic        wr;
   logic [2:0]  cfg_idx;
   logic        is_cfg;
   logic [7:0]  wbyte;
   logic        bypass_all;
   logic [14:0] osr_cnt;
   logic [2:0]  osr_code;
   logic [31:0] rd_mux;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // a new request is taken only when no ack is out, giving one ack per request
   assign req     = cyc_i && stb_i && !st_reg.ack;
   assign wr      = req && we_i && sel_i[0];
   assign cfg_idx = adr_i[4:2];
   assign is_cfg  = (adr_i[1:0] == 2'h0) && (adr_i <= acm_pkg::ACM_OFS_ACQ_CFG5);
   assign wbyte   = dat_i[7:0];

   // settling length tracks the programmed oversampling ratio
   // a write to the oversampling word times its own settling with the new code, not the old one
   assign osr_code   = (wr && is_cfg && cfg_idx == 3'h2) ? wbyte[acm_pkg::ACM_OSR_LSB +: acm_pkg::ACM_OSR_W]
                       : st_reg.cfg[2][acm_pkg::ACM_OSR_LSB +: acm_pkg::ACM_OSR_W];
   assign osr_cnt    = acm_pkg::acm_osr_cycles(osr_code);
   assign bypass_all = st_reg.cfg[1][acm_pkg::ACM_EN_LSB +: acm_pkg::ACM_EN_W]
                       == acm_pkg::ACM_EN_ADC_ONLY;

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always_comb begin
      rd_mux = acm_pkg::ACM_UNMAPPED;
      if (is_cfg) begin
         rd_mux = {24'h000000, st_reg.cfg[cfg_idx]};
      end else if (adr_i == acm_pkg::ACM_OFS_STATUS) begin
         rd_mux = {28'h0000000, st_reg.early_start, bypass_all, st_reg.state == acm_pkg::ACM_ST_READY,
                   st_reg.pga_rst};
      end else if (adr_i == acm_pkg::ACM_OFS_VMULT_CFG) begin
         rd_mux = {24'h000000, st_reg.vmult};
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next         = st_reg;
      st_next.ack     = req;
      st_next.start   = 1'b0;
      st_next.pga_rst = 1'b0;
      if (req) begin
         st_next.rdat = rd_mux;
      end

      // settling counter and state
      unique case (st_reg.state)
         acm_pkg::ACM_ST_IDLE: begin
            st_next.state = acm_pkg::ACM_ST_READY;
         end
         acm_pkg::ACM_ST_SETTLE: begin
            if (st_reg.settle_cnt == 15'h0000) begin
               st_next.state = acm_pkg::ACM_ST_READY;
            end else begin
               st_next.settle_cnt = st_reg.settle_cnt - 15'h0001;
            end
         end
         acm_pkg::ACM_ST_READY: begin
         end
      endcase

      if (wr && is_cfg) begin
         st_next.cfg[cfg_idx] = wbyte;
         st_next.pga_rst      = 1'b1;
         st_next.settle_cnt   = osr_cnt;
         st_next.state        = acm_pkg::ACM_ST_SETTLE;
      end
      if (wr && adr_i == acm_pkg::ACM_OFS_VMULT_CFG) begin
         st_next.vmult = {5'h00, wbyte[2:0]};
      end
      if (wr && adr_i == acm_pkg::ACM_OFS_START && wbyte[0]) begin
         st_next.start = 1'b1;
         // start honoured anytime; flag marks a start taken during settling with stages in use
         if (st_reg.state == acm_pkg::ACM_ST_SETTLE && !bypass_all) begin
            st_next.early_start = 1'b1;
         end
      end
      if (wr && adr_i == acm_pkg::ACM_OFS_STATUS && wbyte[3]) begin
         st_next.early_start = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg       <= '0;
         st_reg.state <= acm_pkg::ACM_ST_IDLE;
         st_reg.vmult <= acm_pkg::ACM_VM_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // multiplier divider
   // ----------------------------------------------------------------
   acm_vmult_div u_div (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .enable_i (st_reg.vmult[acm_pkg::ACM_VM_EN_BIT]),
      .fin_i    (st_reg.vmult[acm_pkg::ACM_VM_FIN_LSB +: 2]),
      .tick_o   (vmult_tick_o),
      .phase_o  (vmult_clk_o)
   );

   // ----------------------------------------------------------------
   // analog side outputs
   // ----------------------------------------------------------------
   logic [1:0] ib_min;
   logic [7:0] fs_div;

   // the smaller of the two bias codes bounds the sampling rate
   always_comb begin
      ib_min = (st_reg.cfg[1][acm_pkg::ACM_PGA_IB_LSB +: 2] < st_reg.cfg[1][acm_pkg::ACM_ADC_IB_LSB +: 2])
               ? st_reg.cfg[1][acm_pkg::ACM_PGA_IB_LSB +: 2] : st_reg.cfg[1][acm_pkg::ACM_ADC_IB_LSB +: 2];
      unique case (ib_min)
         2'h0: fs_div = acm_pkg::ACM_FS_DIV_IB0;
         2'h1: fs_div = acm_pkg::ACM_FS_DIV_IB1;
         2'h2: fs_div = acm_pkg::ACM_FS_DIV_IB2;
         2'h3: fs_div = acm_pkg::ACM_FS_DIV_IB3;
      endcase
   end

   always_comb begin
      analog_o.channel_sel     = st_reg.cfg[0][acm_pkg::ACM_CH_LSB +: acm_pkg::ACM_CH_W];
      analog_o.reference_sel   = st_reg.cfg[0][acm_pkg::ACM_REF_BIT];
      analog_o.stage_enable    = st_reg.cfg[1][acm_pkg::ACM_EN_LSB +: acm_pkg::ACM_EN_W];
      analog_o.gain_stage_bias = st_reg.cfg[1][acm_pkg::ACM_PGA_IB_LSB +: 2];
      analog_o.converter_bias  = st_reg.cfg[1][acm_pkg::ACM_ADC_IB_LSB +: 2];
      analog_o.pga_reset       = st_reg.pga_rst;
      analog_o.fs_div          = fs_div;
   end

   // elementary count field stays in cfg3 only; no output carries it to a decimation filter
   assign conv_start_o = st_reg.start;
   assign settled_o    = (st_reg.state == acm_pkg::ACM_ST_READY) || bypass_all;
   assign vmult_en_o   = st_reg.vmult[acm_pkg::ACM_VM_EN_BIT];
   assign ack_o        = st_reg.ack;
   assign dat_o        = st_reg.rdat;

endmodule // acm_ctl

// File: acm_pkg.sv
// acm_pkg: shared constants and carrier types for the acquisition chain control block.
// assumes a classic wishbone slave with 32-bit data and byte addresses, 10 MHz clock.
package acm_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ACM_OFS_ACQ_CFG1   = 8'h00;
   localparam logic [7:0] ACM_OFS_ACQ_CFG5   = 8'h10;
   localparam logic [7:0] ACM_OFS_START      = 8'h14;
   localparam logic [7:0] ACM_OFS_STATUS     = 8'h18;
   localparam logic [7:0] ACM_OFS_VMULT_CFG  = 8'h1C;
   localparam int         ACM_NUM_CFG        = 5;

   // ----------------------------------------------------------------
   // field positions inside the configuration words
   // ----------------------------------------------------------------
   // cfg1: [4:0] channel select, [5] reference select
   localparam int ACM_CH_LSB      = 0;
   localparam int ACM_CH_W        = 5;
   localparam int ACM_REF_BIT     = 5;
   // cfg2: [3:0] stage enable, [5:4] gain stage bias, [7:6] converter bias
   localparam int ACM_EN_LSB      = 0;
   localparam int ACM_EN_W        = 4;
   localparam int ACM_PGA_IB_LSB  = 4;
   localparam int ACM_ADC_IB_LSB  = 6;
   // cfg3: [2:0] oversampling code (8<<code), [7:4] elementary conversion count
   localparam int ACM_OSR_LSB     = 0;
   localparam int ACM_OSR_W       = 3;
   localparam int ACM_NEL_LSB     = 4;
   localparam int ACM_NEL_W       = 4;
   // vmult: [2] enable, [1:0] clock division
   localparam int ACM_VM_EN_BIT   = 2;
   localparam int ACM_VM_FIN_LSB  = 0;

   localparam logic [3:0]  ACM_EN_ADC_ONLY = 4'h1;
   localparam logic [1:0]  ACM_IB_MAX      = 2'h3;
   localparam logic [7:0]  ACM_CFG_RST     = 8'h00;
   localparam logic [7:0]  ACM_VM_RST      = 8'h00;
   localparam logic [10:0] ACM_OSR_BASE    = 11'h008;
   localparam logic [31:0] ACM_UNMAPPED    = 32'h00000000;

   // max sampling clock divisor per bias code: lower bias needs slower sampling
   localparam logic [7:0] ACM_FS_DIV_IB0 = 8'h08;
   localparam logic [7:0] ACM_FS_DIV_IB1 = 8'h04;
   localparam logic [7:0] ACM_FS_DIV_IB2 = 8'h02;
   localparam logic [7:0] ACM_FS_DIV_IB3 = 8'h01;

   // multiplier divider terminal counts, half-period minus one (divide by 2,4,16,64)
   localparam logic [5:0] ACM_VM_HALF0 = 6'h00;
   localparam logic [5:0] ACM_VM_HALF1 = 6'h01;
   localparam logic [5:0] ACM_VM_HALF2 = 6'h07;
   localparam logic [5:0] ACM_VM_HALF3 = 6'h1F;

   typedef enum logic [2:0] {
      ACM_ST_IDLE   = 3'b001,
      ACM_ST_SETTLE = 3'b010,
      ACM_ST_READY  = 3'b100
   } acm_state_t;

   // settings driven toward the analog chain
   typedef struct packed {
      logic [4:0] channel_sel;
      logic       reference_sel;
      logic [3:0] stage_enable;
      logic [1:0] gain_stage_bias;
      logic [1:0] converter_bias;
      logic       pga_reset;
      logic [7:0] fs_div;
   } acm_analog_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } acm_wb_req_t;

   // settling length helper: oversampling ratio 8<<code as a count of system clock cycles
   function automatic logic [14:0] acm_osr_cycles(input logic [2:0] code);
      acm_osr_cycles = 15'(ACM_OSR_BASE) << code;
   endfunction

endpackage

// File: acm_vmult_div.sv
// acm_vmult_div: clock divider giving the voltage multiplier its switching enable.
// assumes clk_i is the system clock and settings come from registers on the same clock.
`timescale 1ns/10ps
module acm_vmult_div (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       enable_i,
   input  wire logic [1:0] fin_i,
   output logic            tick_o,
   output logic            phase_o
);

   typedef struct packed {
      logic [5:0] cnt;
      logic       phase;
      logic       tick;
   } acm_div_state_t;

   acm_div_state_t st_reg;
   acm_div_state_t st_next;
   logic [5:0]     half;

   // ----------------------------------------------------------------
   // terminal count (half period minus one) per division code
   // ----------------------------------------------------------------
   always_comb begin
      unique case (fin_i)
         2'h0: half = acm_pkg::ACM_VM_HALF0;
         2'h1: half = acm_pkg::ACM_VM_HALF1;
         2'h2: half = acm_pkg::ACM_VM_HALF2;
         2'h3: half = acm_pkg::ACM_VM_HALF3;
      endcase
   end

   // divider runs only while enabled so a disabled multiplier is quiet
   always_comb begin
      st_next      = st_reg;
      st_next.tick = 1'b0;
      if (!enable_i) begin
         st_next.cnt   = 6'h00;
         st_next.phase = 1'b0;
      end else if (st_reg.cnt >= half) begin
         st_next.cnt   = 6'h00;
         st_next.phase = ~st_reg.phase;
         st_next.tick  = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + 6'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick_o  = st_reg.tick;
   assign phase_o = st_reg.phase;

endmodule // acm_vmult_div

// File: acm_ctl_properties.sv
// acm_ctl_properties: port-level checks for acm_ctl.
// assumes one clock domain with synchronous active-high reset.
`timescale 1ns/10ps
module acm_ctl_properties (
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire logic                 cyc_i,
   input wire logic                 stb_i,
   input wire logic                 we_i,
   input wire logic [7:0]           adr_i,
   input wire logic [3:0]           sel_i,
   input wire logic [31:0]          dat_i,
   input wire logic [31:0]          dat_o,
   input wire logic                 ack_o,
   input wire acm_pkg::acm_analog_t analog_o,
   input wire logic                 conv_start_o,
   input wire logic                 settled_o,
   input wire logic                 vmult_en_o,
   input wire logic                 vmult_clk_o,
   input wire logic                 vmult_tick_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic       take, wr0, cfg_wr, bypass;
   logic [1:0] minb;
   // decoded bus events; only byte lane 0 carries writes
   assign take   = cyc_i & stb_i & ~ack_o;
   assign wr0    = take & we_i & sel_i[0];
   assign cfg_wr = wr0 & (adr_i <= acm_pkg::ACM_OFS_ACQ_CFG5) & (adr_i[1:0] == 2'h0);
   assign bypass = analog_o.stage_enable == acm_pkg::ACM_EN_ADC_ONLY;
   assign minb   = (analog_o.gain_stage_bias < analog_o.converter_bias) ?
                   analog_o.gain_stage_bias : analog_o.converter_bias;

   a_ack_latency: assert property (take |=> ack_o) else $error("ack missing after request");
   a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
      else $error("read data above byte 0 not zero");
   a_cfg_restart: assert property (cfg_wr |=> analog_o.pga_reset)
      else $error("config write without stage restart");
   a_restart_cause: assert property (analog_o.pga_reset |-> $past(cfg_wr))
      else $error("stage restart without config write");
   a_settle_hold: assert property (analog_o.pga_reset && !bypass |-> (!settled_o || bypass) [*8])
      else $error("settled too soon after restart");
   a_bypass_ready: assert property (bypass |-> settled_o)
      else $error("bypassed chain not ready");
   a_start_cause: assert property (conv_start_o |->
      $past(wr0 && adr_i == acm_pkg::ACM_OFS_START && dat_i[0]))
      else $error("start pulse without start write");
   a_bias_rate: assert property (!$past(rst_i) && $stable(analog_o.gain_stage_bias) &&
      $stable(analog_o.converter_bias) |-> analog_o.fs_div == (8'h08 >> minb))
      else $error("sampling divisor does not follow bias");
   a_vmult_off: assert property (!vmult_en_o && !$past(vmult_en_o) |-> !vmult_clk_o)
      else $error("multiplier clock runs while disabled");
   a_tick_toggle: assert property (vmult_tick_o |-> $changed(vmult_clk_o))
      else $error("multiplier tick without clock toggle");

   c_restart: cover property (analog_o.pga_reset);
   c_start: cover property (conv_start_o);
   c_tick: cover property (vmult_tick_o);
endmodule // acm_ctl_properties

bind acm_ctl acm_ctl_properties u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
   .dat_i, .dat_o, .ack_o, .analog_o, .conv_start_o, .settled_o, .vmult_en_o, .vmult_clk_o,
   .vmult_tick_o);

// File: acm_analog_model.sv
// acm_analog_model: behavioural gain-stage chain behind the control block.
// assumes settle_i holds the current settling length in system clock cycles.
`timescale 1ns/10ps
module acm_analog_model (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire acm_pkg::acm_analog_t analog_i,
   input  wire logic                 start_i,
   input  wire logic [10:0]          settle_i,
   output logic                      early_o
);
   logic [10:0] age_reg;
   // stages settle from each restart; a start before then spoils the sample (sticky)
   always_ff @(posedge clk_i) begin
      if (rst_i || analog_i.pga_reset) begin
         age_reg <= 11'h000;
      end else if (age_reg != 11'h7FF) begin
         age_reg <= age_reg + 11'h001;
      end
      if (rst_i) begin
         early_o <= 1'b0;
      end else if (start_i && analog_i.stage_enable != acm_pkg::ACM_EN_ADC_ONLY && age_reg < settle_i) begin
         early_o <= 1'b1;
      end
   end
endmodule // acm_analog_model

// File: tb_acm_ctl.sv
// tb_acm_ctl: self-checking bench for the acquisition chain control block.
// assumes a 10 MHz system clock and a classic single-cycle bus master.
`timescale 1ns/10ps
module tb_acm_ctl;
   localparam logic [7:0] VM = acm_pkg::ACM_OFS_VMULT_CFG;
   localparam logic [7:0] ST = acm_pkg::ACM_OFS_STATUS;
   localparam logic [7:0] GO = acm_pkg::ACM_OFS_START;
   logic                 clk_i = 1'b0;
   logic                 rst_i = 1'b1;
   acm_pkg::acm_wb_req_t req = '0;
   acm_pkg::acm_analog_t analog_o;
   logic [31:0]          dat_o, rd;
   logic                 ack_o, conv_start_o, settled_o, vmult_en_o, vmult_clk_o, early, pga_seen, go_seen;
   logic [10:0]          settle = 11'h008;
   int                   mismatches = 0;
   int                   num_checks = 0;

   always #50 clk_i = ~clk_i;

   acm_ctl dut (.clk_i, .rst_i, .cyc_i(req.cyc), .stb_i(req.stb), .we_i(req.we), .adr_i(req.adr),
      .sel_i(req.sel), .dat_i(req.dat), .dat_o, .ack_o, .analog_o, .conv_start_o, .settled_o,
      .vmult_en_o, .vmult_clk_o, .vmult_tick_o());
   acm_analog_model u_model (.clk_i, .rst_i, .analog_i(analog_o), .start_i(conv_start_o),
      .settle_i(settle), .early_o(early));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", s, e, g);
      end
   endtask

   // one classic cycle; pulses that come with ack are caught at the ack edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n = 0;
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         end_sim();
      end
      rd = dat_o;
      pga_seen = analog_o.pga_reset;
      go_seen = conv_start_o;
      req <= '0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hF);
   endtask

   task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, 4'hF);
      chk(s, e, rd);
   endtask

   // counts system clocks until the multiplier clock reaches level v
   task automatic lvl(input logic v, inout int n);
      while (vmult_clk_o !== v && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 200) begin
         mismatches++;
         end_sim();
      end
   endtask

   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   task automatic t_regs();
      rdc("vmult_rst", VM, {24'h0, acm_pkg::ACM_VM_RST});
      wb(1'b1, VM, 32'h7, 4'hE);
      rdc("vmult_nosel", VM, 32'h0);
      wr(8'h40, 32'hFF);
      rdc("unmapped", 8'h40, acm_pkg::ACM_UNMAPPED);
      $display("test regs done");
   endtask

   task automatic t_vmult();
      int divs [4] = '{2, 4, 16, 64};
      int n;
      for (int f = 0; f < 4; f++) begin
         wr(VM, {29'h0, 1'b1, f[1:0]});
         rdc("vmult_rd", VM, {29'h0, 1'b1, f[1:0]});
         n = 0;
         lvl(1'b0, n);
         lvl(1'b1, n);
         n = 0;
         lvl(1'b0, n);
         lvl(1'b1, n);
         chk("vmult_period", divs[f], n);
      end
      wr(VM, 32'h0);
      repeat (2) @(posedge clk_i);
      chk("vmult_off", 32'h0, {vmult_en_o, vmult_clk_o});
      $display("test vmult done");
   endtask

   task automatic t_chan();
      for (int i = 0; i < 5; i++) begin
         wr(8'(i * 4), 32'h0);
         chk("cfg_restart", 32'h1, pga_seen);
      end
      wr(8'h00, 32'h35);
      @(posedge clk_i);
      chk("chan_sel", 32'h35, {analog_o.reference_sel, analog_o.channel_sel});
      wb(1'b1, 8'h00, 32'h2A, 4'hE);
      chk("nosel_restart", 32'h0, pga_seen);
      rdc("chan_rd", 8'h00, 32'h35);
      $display("test chan done");
   endtask

   task automatic t_settle();
      int n;
      wr(8'h04, 32'hFF);
      chk("bias_max", 32'hFF, {analog_o.converter_bias, analog_o.gain_stage_bias, analog_o.stage_enable});
      repeat (2) @(posedge clk_i);
      chk("fs_div_max", 32'h1, analog_o.fs_div);
      wr(8'h04, 32'h9F);
      repeat (2) @(posedge clk_i);
      chk("fs_div_low", 32'h4, analog_o.fs_div);
      for (int c = 0; c < 8; c += 7) begin
         settle <= 11'h008 << c;
         wr(8'h08, {24'h0, 4'h2, 1'b0, c[2:0]});
         n = 0;
         while (settled_o !== 1'b1 && n < 1100) begin
            @(posedge clk_i);
            n++;
         end
         if (n >= 1100) begin
            mismatches++;
            end_sim();
         end
         chk("settle_len", 32'h1, 32'(n >= settle - 2 && n <= settle + 2));
      end
      rdc("nel_rd", 8'h08, 32'h27);
      $display("test settle done");
   endtask

   task automatic t_start();
      wr(8'h04, 32'hF1);
      @(posedge clk_i);
      chk("bypass_ready", 32'h1, settled_o);
      wr(GO, 32'h1);
      chk("start_pulse", 32'h1, go_seen);
      wb(1'b0, ST, 32'h0, 4'hF);
      chk("bypass_stat", 32'h4, rd & 32'hC);
      chk("model_clean", 32'h0, early);
      wr(8'h04, 32'hFF);
      wr(GO, 32'h1);
      chk("early_pulse", 32'h1, go_seen);
      wb(1'b0, ST, 32'h0, 4'hF);
      chk("early_stat", 32'h8, rd & 32'hC);
      chk("model_early", 32'h1, early);
      wr(ST, 32'h8);
      wb(1'b0, ST, 32'h0, 4'hF);
      chk("early_clr", 32'h0, rd & 32'h8);
      wr(8'h04, 32'h0);
      @(posedge clk_i);
      chk("idle_off", 32'h0, analog_o.stage_enable);
      $display("test start done");
   endtask

   // reset in mid-run with the multiplier running and a channel programmed
   task automatic t_reset();
      wr(VM, 32'h6);
      wr(8'h00, 32'h1F);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("rst_vmult_out", 32'h0, {vmult_en_o, vmult_clk_o});
      rdc("rst_vmult", VM, {24'h0, acm_pkg::ACM_VM_RST});
      rdc("rst_cfg", 8'h00, {24'h0, acm_pkg::ACM_CFG_RST});
      $display("test reset done");
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_vmult();
      t_chan();
      t_settle();
      t_start();
      t_reset();
      end_sim();
   end
endmodule // tb_acm_ctl
